// ===== twm_regs.svh
// Register offsets, field positions, reset values and output action codes of the waveform timer
`ifndef TWM_REGS_SVH
`define TWM_REGS_SVH

// Register offsets (byte addresses)
`define TWM_OFS_CTRL     8'h00
`define TWM_OFS_COUNT    8'h04
`define TWM_OFS_CMPA     8'h08
`define TWM_OFS_CMPB     8'h0c
`define TWM_OFS_CAPTOP   8'h10
`define TWM_OFS_FLAGS    8'h14

// Flag bit positions
`define TWM_FLG_OVF      0
`define TWM_FLG_CMPA     1
`define TWM_FLG_CMPB     2
`define TWM_FLG_CAP      3

// Reset values
`define TWM_RST_CTRL     16'h0000
`define TWM_RST_WORD     16'h0000
`define TWM_RST_FLAGS    4'h0

// Counter limits
`define TWM_BOTTOM       16'h0000
`define TWM_MAX          16'hffff
`define TWM_TOP_8BIT     16'h00ff
`define TWM_TOP_9BIT     16'h01ff
`define TWM_TOP_10BIT    16'h03ff

// Output action codes
`define TWM_ACT_NONE     2'h0
`define TWM_ACT_TOGGLE   2'h1
`define TWM_ACT_CLEAR    2'h2
`define TWM_ACT_SET      2'h3

`endif

// ===== twm_pkg.sv
// Types shared by the waveform timer
package twm_pkg;

	typedef enum logic [1:0] {
		TWM_UP   = 2'b01,
		TWM_DOWN = 2'b10
	} twm_dir_t;

	typedef enum logic [3:0] {
		TWM_CLS_NONE  = 4'b0001,
		TWM_CLS_CLR   = 4'b0010,
		TWM_CLS_FAST  = 4'b0100,
		TWM_CLS_PHASE = 4'b1000
	} twm_cls_t;

	typedef struct packed {
		twm_cls_t    cls;
		logic        fixed;
		logic        top_cap;
		logic        top_cmpa;
		logic [15:0] top_val;
	} twm_mode_t;

	typedef struct packed {
		logic [5:0]      rsvd;
		logic [1:0]      pin_dir;
		logic [1:0][1:0] act;
		logic [3:0]      mode;
	} twm_ctrl_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} twm_bus_t;

endpackage : twm_pkg

// ===== twm_top.sv
// Waveform timer: clear-on-match, fast and phase-correct counting with compare outputs
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "twm_regs.svh"

// Behaviour
// - Clear-on-match TOP sets compare-A or capture flag
// - Clear-on-match TOP unbuffered; missed match wraps
// - Clear-on-match action 1 toggles compare-A output
// - Toggle period is 2*N*(1+compare-A)
// - Clear-on-match overflow flag set at MAX wrap
// - Modes 5,6,7,14,15 count up, restart
// - Fast: 2 set match/clear wrap, 3 inverse
// - Fast TOP fixed, capture or compare-A; clears next
// - Fast overflow at TOP plus TOP-source flag
// - PWM compare match sets channel flag
// - Fixed TOP masks compare bits on write
// - Fast capture TOP unbuffered; missed match wraps
// - PWM compare writes buffered, loaded at TOP
// - Fast: compare zero spikes; compare TOP constant
// - Mode 15 action 1 toggles compare-A output
// - Pin driven only while direction bit set
// - Modes 1,2,3,10,11 count up then down
// - Phase: clear on up match, set down
// - Phase TOP fixed, capture or compare-A
// - Fast period is N*(1+TOP)
// - Modes 4 and 12 clear at compare-A/capture
// - Action 0 leaves compare output unchanged
// - Dual slope holds TOP one tick, reverses
module twm_top
	import twm_pkg::*;
(
	// Clock and reset
	input  wire logic      sys_clk_i,
	input  wire logic      arst_n_i,
	// Prescaler enable
	input  wire logic      tick_i,
	// Register port
	input  wire twm_bus_t  bus_i,
	output logic [15:0]    rd_data_o,
	// Compare pins
	output logic           cmpa_out_o,
	output logic           cmpa_oe_o,
	output logic           cmpb_out_o,
	output logic           cmpb_oe_o
);

	// Fixed TOP by resolution code
	function automatic logic [15:0] fixed_top(input logic [1:0] res);
		logic [15:0] t;
		t = `TWM_MAX;
		unique case (res)
			2'h1:    t = `TWM_TOP_8BIT;
			2'h2:    t = `TWM_TOP_9BIT;
			2'h3:    t = `TWM_TOP_10BIT;
			default: t = `TWM_MAX;
		endcase
		return t;
	endfunction : fixed_top

	// Mode decode
	function automatic twm_mode_t decode_mode(input logic [3:0] m);
		twm_mode_t d;
		d.cls      = TWM_CLS_NONE;
		d.fixed    = 1'b0;
		d.top_cap  = 1'b0;
		d.top_cmpa = 1'b0;
		d.top_val  = `TWM_MAX;
		unique case (m)
			4'h1, 4'h2, 4'h3: begin
				d.cls     = TWM_CLS_PHASE;
				d.fixed   = 1'b1;
				d.top_val = fixed_top(m[1:0]);
			end
			4'h5, 4'h6, 4'h7: begin
				d.cls     = TWM_CLS_FAST;
				d.fixed   = 1'b1;
				d.top_val = fixed_top(m[1:0]);
			end
			4'h4: begin
				d.cls      = TWM_CLS_CLR;
				d.top_cmpa = 1'b1;
			end
			4'hc: begin
				d.cls     = TWM_CLS_CLR;
				d.top_cap = 1'b1;
			end
			4'ha: begin
				d.cls     = TWM_CLS_PHASE;
				d.top_cap = 1'b1;
			end
			4'hb: begin
				d.cls      = TWM_CLS_PHASE;
				d.top_cmpa = 1'b1;
			end
			4'he: begin
				d.cls     = TWM_CLS_FAST;
				d.top_cap = 1'b1;
			end
			4'hf: begin
				d.cls      = TWM_CLS_FAST;
				d.top_cmpa = 1'b1;
			end
			default: d.cls = TWM_CLS_NONE;
		endcase
		return d;
	endfunction : decode_mode

	twm_ctrl_t        ctrl_ff;
	logic [15:0]      cnt_ff;
	twm_dir_t         dir_ff;
	logic [15:0]      cap_top_ff;
	logic [1:0][15:0] buf_ff;
	logic [1:0][15:0] cmp_ff;
	logic [1:0]       oc_ff;
	logic [3:0]       flag_ff;
	logic [15:0]      rd_data_ff;

	twm_mode_t        md;
	logic [15:0]      top;
	logic             at_top;
	logic             is_pwm;
	logic [1:0]       match;
	logic [3:0]       flag_set;
	logic             wr_ctrl;
	logic             wr_count;
	logic             wr_cap;
	logic             wr_flags;

	assign md       = decode_mode(ctrl_ff.mode);
	assign is_pwm   = (md.cls == TWM_CLS_FAST) || (md.cls == TWM_CLS_PHASE);
	assign wr_ctrl  = bus_i.wr && (bus_i.addr == `TWM_OFS_CTRL);
	assign wr_count = bus_i.wr && (bus_i.addr == `TWM_OFS_COUNT);
	assign wr_cap   = bus_i.wr && (bus_i.addr == `TWM_OFS_CAPTOP);
	assign wr_flags = bus_i.wr && (bus_i.addr == `TWM_OFS_FLAGS);

	assign top    = md.top_cap ? cap_top_ff : (md.top_cmpa ? cmp_ff[0] : md.top_val);
	assign at_top = (cnt_ff == top);

	// Control register
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_ff <= `TWM_RST_CTRL;
		end else if (wr_ctrl) begin
			ctrl_ff <= {6'h00, bus_i.wdata[9:0]};
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cap_top_ff <= `TWM_RST_WORD;
		end else if (wr_cap) begin
			cap_top_ff <= bus_i.wdata;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_ff <= `TWM_BOTTOM;
			dir_ff <= TWM_UP;
		end else if (wr_count) begin
			cnt_ff <= bus_i.wdata;
		end else if (tick_i) begin
			unique case (md.cls)
				// TOP held one tick, then reverse
				TWM_CLS_PHASE: begin
					if (dir_ff == TWM_UP) begin
						if (at_top) begin
							dir_ff <= TWM_DOWN;
							cnt_ff <= 16'(cnt_ff - 16'h0001);
						end else begin
							cnt_ff <= 16'(cnt_ff + 16'h0001);
						end
					end else if (cnt_ff == `TWM_BOTTOM) begin
						dir_ff <= TWM_UP;
						cnt_ff <= 16'(cnt_ff + 16'h0001);
					end else begin
						cnt_ff <= 16'(cnt_ff - 16'h0001);
					end
				end
				// period of one plus TOP ticks
				TWM_CLS_FAST, TWM_CLS_CLR: begin
					dir_ff <= TWM_UP;
					cnt_ff <= at_top ? `TWM_BOTTOM : 16'(cnt_ff + 16'h0001);
				end
				default: begin
					dir_ff <= TWM_UP;
					cnt_ff <= 16'(cnt_ff + 16'h0001);
				end
			endcase
		end
	end

	// Flag set events
	always_comb begin
		flag_set = 4'h0;
		if (tick_i) begin
			unique case (md.cls)
				TWM_CLS_CLR, TWM_CLS_NONE:
					flag_set[`TWM_FLG_OVF] = (cnt_ff == `TWM_MAX);
				TWM_CLS_FAST:
					flag_set[`TWM_FLG_OVF] = at_top;
				TWM_CLS_PHASE:
					flag_set[`TWM_FLG_OVF] = (dir_ff == TWM_DOWN) && (cnt_ff == `TWM_BOTTOM);
				default:
					flag_set[`TWM_FLG_OVF] = 1'b0;
			endcase
			flag_set[`TWM_FLG_CMPA] = match[0];
			flag_set[`TWM_FLG_CMPB] = match[1];
			if (md.cls != TWM_CLS_NONE && at_top) begin
				flag_set[`TWM_FLG_CAP]  = md.top_cap;
				flag_set[`TWM_FLG_CMPA] = match[0] || md.top_cmpa;
			end
		end
	end

	// Sticky flags, write one to clear, set wins
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flag_ff <= `TWM_RST_FLAGS;
		end else begin
			flag_ff <= (flag_ff & ~(wr_flags ? bus_i.wdata[3:0] : 4'h0)) | flag_set;
		end
	end

	// Per-channel compare buffer, active value and output
	for (genvar i = 0; i < 2; i++) begin : g_chan
		localparam logic [7:0] OFS = (i == 0) ? `TWM_OFS_CMPA : `TWM_OFS_CMPB;
		logic        wr_cmp;
		logic [15:0] wval;
		logic        tog_ok;

		assign wr_cmp = bus_i.wr && (bus_i.addr == OFS);
		assign wval   = md.fixed ? (bus_i.wdata & md.top_val) : bus_i.wdata;
		assign match[i] = (cnt_ff == cmp_ff[i]);
		// toggle only with compare-A as TOP
		assign tog_ok = (i == 0) && md.top_cmpa;

		// buffered in PWM, loaded at TOP
		always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				buf_ff[i] <= `TWM_RST_WORD;
				cmp_ff[i] <= `TWM_RST_WORD;
			end else begin
				if (wr_cmp) begin
					buf_ff[i] <= wval;
				end
				if (wr_cmp && !is_pwm) begin
					cmp_ff[i] <= wval;
				end else if (tick_i && is_pwm && at_top) begin
					cmp_ff[i] <= buf_ff[i];
				end
			end
		end

		always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				oc_ff[i] <= 1'b0;
			end else if (tick_i) begin
				unique case (md.cls)
					// toggle, clear or set on match
					TWM_CLS_CLR, TWM_CLS_NONE: begin
						if (match[i]) begin
							unique case (ctrl_ff.act[i])
								`TWM_ACT_TOGGLE: oc_ff[i] <= ~oc_ff[i];
								`TWM_ACT_CLEAR:  oc_ff[i] <= 1'b0;
								`TWM_ACT_SET:    oc_ff[i] <= 1'b1;
								default:         oc_ff[i] <= oc_ff[i];
							endcase
						end
					end
					// match wins at TOP, constant level
					TWM_CLS_FAST: begin
						if (match[i]) begin
							unique case (ctrl_ff.act[i])
								`TWM_ACT_TOGGLE: oc_ff[i] <= tog_ok ? ~oc_ff[i] : oc_ff[i];
								`TWM_ACT_CLEAR:  oc_ff[i] <= 1'b1;
								`TWM_ACT_SET:    oc_ff[i] <= 1'b0;
								default:         oc_ff[i] <= oc_ff[i];
							endcase
						end else if (at_top) begin
							if (ctrl_ff.act[i] == `TWM_ACT_CLEAR) begin
								oc_ff[i] <= 1'b0;
							end else if (ctrl_ff.act[i] == `TWM_ACT_SET) begin
								oc_ff[i] <= 1'b1;
							end
						end
					end
					TWM_CLS_PHASE: begin
						if (match[i]) begin
							unique case (ctrl_ff.act[i])
								`TWM_ACT_TOGGLE: oc_ff[i] <= tog_ok ? ~oc_ff[i] : oc_ff[i];
								`TWM_ACT_CLEAR:  oc_ff[i] <= (dir_ff == TWM_DOWN);
								`TWM_ACT_SET:    oc_ff[i] <= (dir_ff == TWM_UP);
								default:         oc_ff[i] <= oc_ff[i];
							endcase
						end
					end
					default: oc_ff[i] <= oc_ff[i];
				endcase
			end
		end
	end

	// Read data, one cycle after the strobe only
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_data_ff <= `TWM_RST_WORD;
		end else if (bus_i.rd) begin
			unique case (bus_i.addr)
				`TWM_OFS_CTRL:   rd_data_ff <= ctrl_ff;
				`TWM_OFS_COUNT:  rd_data_ff <= cnt_ff;
				`TWM_OFS_CMPA:   rd_data_ff <= buf_ff[0];
				`TWM_OFS_CMPB:   rd_data_ff <= buf_ff[1];
				`TWM_OFS_CAPTOP: rd_data_ff <= cap_top_ff;
				`TWM_OFS_FLAGS:  rd_data_ff <= {12'h000, flag_ff};
				default:         rd_data_ff <= `TWM_RST_WORD;
			endcase
		end else begin
			rd_data_ff <= `TWM_RST_WORD;
		end
	end

	assign rd_data_o  = rd_data_ff;
	assign cmpa_out_o = oc_ff[0];
	assign cmpb_out_o = oc_ff[1];
	assign cmpa_oe_o  = ctrl_ff.pin_dir[0];
	assign cmpb_oe_o  = ctrl_ff.pin_dir[1];

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_up_at_top;
		tick_i && !bus_i.wr && md.cls == TWM_CLS_PHASE && dir_ff == TWM_UP && at_top;
	endsequence

	sequence s_single_top;
		tick_i && !bus_i.wr && (md.cls == TWM_CLS_FAST || md.cls == TWM_CLS_CLR) && at_top;
	endsequence

	a_single_clear: assert property (
		s_single_top |=> cnt_ff == `TWM_BOTTOM
	) else $error("single slope counter did not clear after TOP");

	a_dual_reverse: assert property (
		s_up_at_top |=> dir_ff == TWM_DOWN && cnt_ff == 16'($past(top) - 16'h0001)
	) else $error("dual slope did not reverse at TOP");

	a_clr_ovf: assert property (
		tick_i && md.cls == TWM_CLS_CLR && cnt_ff == `TWM_MAX |=> flag_ff[`TWM_FLG_OVF]
	) else $error("overflow flag missing at MAX wrap");

	a_fast_top_flags: assert property (
		(s_single_top and (md.cls == TWM_CLS_FAST))
			|=> flag_ff[`TWM_FLG_OVF] && ($past(md.top_cap) ? flag_ff[`TWM_FLG_CAP] : 1'b1)
			&& ($past(md.top_cmpa) ? flag_ff[`TWM_FLG_CMPA] : 1'b1)
	) else $error("fast mode TOP flags missing");

	a_match_flag: assert property (
		tick_i && is_pwm && match[1] |=> flag_ff[`TWM_FLG_CMPB]
	) else $error("compare B flag missing on match");

	a_buffer_load: assert property (
		(s_single_top and (md.cls == TWM_CLS_FAST)) |=> cmp_ff[0] == $past(buf_ff[0])
	) else $error("compare A not loaded from buffer at TOP");

	a_clr_toggle: assert property (
		tick_i && md.cls == TWM_CLS_CLR && match[0] && ctrl_ff.act[0] == `TWM_ACT_TOGGLE
			|=> cmpa_out_o != $past(cmpa_out_o)
	) else $error("compare A output did not toggle");

	a_none_stable: assert property (
		ctrl_ff.act[1] == `TWM_ACT_NONE |=> $stable(cmpb_out_o)
	) else $error("output changed with action none");

	a_fixed_mask: assert property (
		bus_i.wr && bus_i.addr == `TWM_OFS_CMPB && md.fixed
			|=> (buf_ff[1] & ~$past(md.top_val)) == 16'h0000
	) else $error("compare bits above fixed TOP not masked");

	a_tick_gate: assert property (
		!tick_i && !bus_i.wr |=> $stable(cnt_ff) && $stable(cmp_ff) && $stable(oc_ff)
	) else $error("timer state moved without tick");

endmodule : twm_top

// ===== twm_top_bench.sv
// Self-checking bench for the waveform timer
`timescale 1ns/1ps
`include "twm_regs.svh"

module twm_top_bench
	import twm_pkg::*;
;
	// Design ports
	logic        sys_clk_i = 1'b0;
	logic        arst_n_i  = 1'b0;
	logic        tick_i    = 1'b0;
	twm_bus_t    bus_i     = '0;
	logic [15:0] rd_data_o;
	logic        cmpa_out_o;
	logic        cmpa_oe_o;
	logic        cmpb_out_o;
	logic        cmpb_oe_o;
	// Bench state
	int          num_errors = 0;
	int          num_checks = 0;
	int          k;
	logic [15:0] cnt_tab [9] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0003,
		16'h0002, 16'h0001, 16'h0000, 16'h0001};
	logic        outb_tab [9] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
	logic [15:0] fix_mode_tab [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0006, 16'h0007};
	logic [15:0] fix_top_tab [5] = '{`TWM_TOP_8BIT, `TWM_TOP_9BIT, `TWM_TOP_10BIT,
		`TWM_TOP_9BIT, `TWM_TOP_10BIT};

	twm_top twm_top_i (
		.sys_clk_i  (sys_clk_i),
		.arst_n_i   (arst_n_i),
		.tick_i     (tick_i),
		.bus_i      (bus_i),
		.rd_data_o  (rd_data_o),
		.cmpa_out_o (cmpa_out_o),
		.cmpa_oe_o  (cmpa_oe_o),
		.cmpb_out_o (cmpb_out_o),
		.cmpb_oe_o  (cmpb_oe_o)
	);

	always #20 sys_clk_i = ~sys_clk_i;

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk_i);
		bus_i <= '0;
		@(negedge sys_clk_i);
	endtask : wr

	task automatic chk_reg(input string what, input logic [7:0] a, input logic [15:0] exp);
		@(posedge sys_clk_i);
		bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge sys_clk_i);
		bus_i <= '0;
		@(negedge sys_clk_i);
		check(what, rd_data_o, exp);
	endtask : chk_reg

	// n prescaler ticks per call
	task automatic step(input int n);
		repeat (n) begin
			@(posedge sys_clk_i);
			tick_i <= 1'b1;
			@(posedge sys_clk_i);
			tick_i <= 1'b0;
		end
		@(negedge sys_clk_i);
	endtask : step

	task automatic setup(input logic [15:0] c, input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] n);
		wr(`TWM_OFS_CTRL, 16'h0000);
		wr(`TWM_OFS_CMPA, a);
		wr(`TWM_OFS_CMPB, b);
		wr(`TWM_OFS_COUNT, n);
		wr(`TWM_OFS_FLAGS, 16'h000f);
		wr(`TWM_OFS_CTRL, c);
	endtask : setup

	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		num_errors++;
		give_verdict();
	end

	initial begin
		repeat (3) @(posedge sys_clk_i);
		arst_n_i <= 1'b1;
		// Reset values and unmapped place
		chk_reg("ctrl", `TWM_OFS_CTRL, `TWM_RST_CTRL);
		chk_reg("count", `TWM_OFS_COUNT, `TWM_RST_WORD);
		chk_reg("cmpa", `TWM_OFS_CMPA, `TWM_RST_WORD);
		chk_reg("captop", `TWM_OFS_CAPTOP, `TWM_RST_WORD);
		chk_reg("flags", `TWM_OFS_FLAGS, 16'h0000);
		chk_reg("unmapped", 8'h18, 16'h0000);
		check("outa", 16'(cmpa_out_o), 16'h0000);
		// Clear-on-match, compare-A TOP, toggle
		setup(16'h0114, 16'h0003, 16'h0000, 16'h0000);
		check("oea", 16'(cmpa_oe_o), 16'h0001);
		for (k = 1; k <= 8; k++) begin
			step(1);
			chk_reg("count", `TWM_OFS_COUNT, 16'(k % 4));
			check("outa", 16'(cmpa_out_o), 16'((k / 4) % 2));
		end
		chk_reg("flags", `TWM_OFS_FLAGS, 16'h0006);
		wr(`TWM_OFS_COUNT, 16'h0010);
		step(1);
		chk_reg("count", `TWM_OFS_COUNT, 16'h0011);
		repeat (5) @(posedge sys_clk_i);
		chk_reg("count", `TWM_OFS_COUNT, 16'h0011);
		wr(`TWM_OFS_FLAGS, 16'h000f);
		wr(`TWM_OFS_COUNT, `TWM_MAX);
		step(1);
		chk_reg("count", `TWM_OFS_COUNT, `TWM_BOTTOM);
		chk_reg("flags", `TWM_OFS_FLAGS, 16'h0001);
		// Fast, fixed 8-bit TOP, inverting channel B
		setup(16'h02c5, 16'h0000, 16'h0000, 16'h00fe);
		wr(`TWM_OFS_CMPB, 16'h1234);
		chk_reg("cmpb", `TWM_OFS_CMPB, 16'h0034);
		check("oeb", 16'(cmpb_oe_o), 16'h0001);
		check("oea", 16'(cmpa_oe_o), 16'h0000);
		step(2);
		chk_reg("count", `TWM_OFS_COUNT, 16'h0000);
		check("outb", 16'(cmpb_out_o), 16'h0001);
		wr(`TWM_OFS_COUNT, 16'h0033);
		step(2);
		check("outb", 16'(cmpb_out_o), 16'h0000);
		wr(`TWM_OFS_COUNT, 16'h00fd);
		step(3);
		check("outb", 16'(cmpb_out_o), 16'h0001);
		// Fast, compare-A TOP
		setup(16'h012f, 16'h0003, 16'h0000, 16'h0000);
		step(3);
		wr(`TWM_OFS_FLAGS, 16'h000f);
		step(1);
		chk_reg("count", `TWM_OFS_COUNT, 16'h0000);
		chk_reg("flags", `TWM_OFS_FLAGS, 16'h0003);
		check("outa", 16'(cmpa_out_o), 16'h0001);
		step(1);
		chk_reg("flags", `TWM_OFS_FLAGS, 16'h0007);
		check("outb", 16'(cmpb_out_o), 16'h0001);
		wr(`TWM_OFS_CMPA, 16'h0005);
		chk_reg("cmpa", `TWM_OFS_CMPA, 16'h0005);
		step(3);
		chk_reg("count", `TWM_OFS_COUNT, 16'h0000);
		step(5);
		chk_reg("count", `TWM_OFS_COUNT, 16'h0005);
		step(1);
		chk_reg("count", `TWM_OFS_COUNT, 16'h0000);
		check("outa", 16'(cmpa_out_o), 16'h0001);
		wr(`TWM_OFS_CTRL, 16'h011f);
		step(6);
		check("outa", 16'(cmpa_out_o), 16'h0000);
		step(6);
		check("outa", 16'(cmpa_out_o), 16'h0001);
		// Clear-on-match, capture TOP, then fast capture TOP
		// register TOP at least three
		setup(16'h000c, 16'h0002, 16'h0002, 16'h0000);
		wr(`TWM_OFS_CAPTOP, 16'h0003);
		step(3);
		wr(`TWM_OFS_FLAGS, 16'h000f);
		step(1);
		chk_reg("count", `TWM_OFS_COUNT, 16'h0000);
		chk_reg("flags", `TWM_OFS_FLAGS, 16'h0008);
		wr(`TWM_OFS_CTRL, 16'h000e);
		wr(`TWM_OFS_COUNT, 16'h0005);
		step(1);
		chk_reg("count", `TWM_OFS_COUNT, 16'h0006);
		// Phase-correct, compare-A TOP, non-inverting channel B
		setup(16'h028b, 16'h0004, 16'h0002, 16'h0000);
		for (k = 0; k < 9; k++) begin
			step(1);
			chk_reg("count", `TWM_OFS_COUNT, cnt_tab[k]);
			check("outb", 16'(cmpb_out_o), 16'(outb_tab[k]));
		end
		// Phase-correct, capture TOP
		wr(`TWM_OFS_CAPTOP, 16'h0004);
		wr(`TWM_OFS_CTRL, 16'h000a);
		wr(`TWM_OFS_COUNT, 16'h0003);
		step(2);
		chk_reg("count", `TWM_OFS_COUNT, 16'h0003);
		// Remaining fixed TOP modes mask compare writes
		for (k = 0; k < 5; k++) begin
			wr(`TWM_OFS_CTRL, fix_mode_tab[k]);
			wr(`TWM_OFS_CMPA, 16'hffff);
			chk_reg("cmpa", `TWM_OFS_CMPA, fix_top_tab[k]);
		end
		give_verdict();
	end
endmodule : twm_top_bench
